/* sci_transmitter_port.sv */
/*
  Serial transmitter with break and idle characters, a break-detecting
  receiver and the two-pin port whose pins it shares, behind an Avalon-MM
  slave with one wait state. Assumes the oversample ticks are one-cycle
  pulses on clk at sixteen times the baud rate.
*/
`timescale 1ns/1ns
`include "sci_port_regs.svh"

module sci_transmitter_port (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire sci_port_pkg::bus_addr_t address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire sci_port_pkg::bus_data_t writedata,
  input  wire logic [3:0]             byteenable,
  output sci_port_pkg::bus_data_t      readdata,
  output logic                        waitrequest,
  input  wire logic [1:0]             pinIn,
  output logic [1:0]                  pinOut,
  output logic [1:0]                  pinOe,
  input  wire logic                   oversampleTickA,
  input  wire logic                   oversampleTickB,
  input  wire logic                   baudSourceSelect,
  output logic                        txIrq
);
  import sci_port_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic        serialEnable;
  logic        char9;
  logic        txInvert;
  logic        txEnable;
  logic        sendBreak;
  logic        txEmptyIrqEn;
  logic        txCompleteIrqEn;
  logic        txNinth;
  logic [7:0]  txData;
  logic        txEmpty;
  logic        txComplete;
  logic        emptyArmed;
  logic        needPreamble;
  logic        idleQueued;
  logic        breakTail;
  logic        txLoad;
  logic [10:0] txFrame;
  logic [3:0]  txBits;
  logic        tick;
  logic        accept;
  logic        wrAccept;
  logic        rdAccept;
  logic        lane0;
  logic [1:0]  latch;
  logic [1:0]  dir;
  logic [1:0]  readBit;
  logic [1:0]  pinLevel;
  logic        txPinOut;
  logic        dataTransfer;
  logic [7:0]  rxData;
  logic        rxNinth;
  logic        rxFull;
  logic        frameErr;
  logic        breakFlag;
  rx_state_e   rxState;
  logic [3:0]  rxPhase;
  logic [3:0]  rxCount;
  logic [9:0]  rxShift;
  logic        rxPrev;
  logic [9:0]  next_rxShift;
  logic [7:0]  next_rxData;
  logic        next_rxNinth;
  logic        rxDone;
  bus_data_t   next_readdata;

  tx_shift_if txIf ();

  //////////////////////////////////////////////////////////////////////////
  // bus slave: every access takes exactly one wait state

  assign accept   = (read || write) && !waitrequest;
  assign wrAccept = write && !waitrequest;
  assign rdAccept = read && !waitrequest;
  assign lane0    = byteenable[0];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      waitrequest <= 1'b1;
    else if (!waitrequest)
      waitrequest <= 1'b1;
    else if (read || write)
      waitrequest <= 1'b0;
  end

  always_comb
  begin
    next_readdata = 32'h0000_0000;
    unique case (address)
      `OFS_CTRL1:
      begin
        next_readdata[`C1_ENABLE] = serialEnable;
        next_readdata[`C1_CHAR9]  = char9;
        next_readdata[`C1_TX_POLARITY_INVERT]  = txInvert;
      end
      `OFS_CTRL2:
      begin
        next_readdata[`C2_TE]   = txEnable;
        next_readdata[`C2_SBK]  = sendBreak;
        next_readdata[`C2_TEIE] = txEmptyIrqEn;
        next_readdata[`C2_TX_COMPLETE_IRQ_ENABLE] = txCompleteIrqEn;
      end
      `OFS_PORT_LATCH: next_readdata[1:0] = readBit;
      `OFS_PORT_DIR:   next_readdata[1:0] = dir;
      `OFS_STATUS1:
      begin
        next_readdata[`S1_TXEMPTY]    = txEmpty;
        next_readdata[`S1_TXCOMPLETE] = txComplete;
        next_readdata[`S1_RXFULL]     = rxFull;
        next_readdata[`S1_FRAMERR]    = frameErr;
      end
      `OFS_STATUS2: next_readdata[`S2_BREAK] = breakFlag;
      `OFS_DATA:    next_readdata[7:0] = rxData;
      `OFS_CTRL3:
      begin
        next_readdata[`C3_RXNINTH] = rxNinth;
        next_readdata[`C3_TXNINTH] = txNinth;
      end
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // sampled as waitrequest drops, so it stands at the accepting edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      readdata <= 32'h0000_0000;
    else if (waitrequest && read)
      readdata <= next_readdata;
  end

  //////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {txInvert, char9, serialEnable} <= 3'(`CTRL_RESET);
      {txCompleteIrqEn, txEmptyIrqEn, sendBreak, txEnable} <= `CTRL_RESET;
      txNinth <= 1'b0;
    end
    else if (wrAccept && lane0)
    begin
      if (address == `OFS_CTRL1)
      begin
        serialEnable <= writedata[`C1_ENABLE];
        char9        <= writedata[`C1_CHAR9];
        txInvert     <= writedata[`C1_TX_POLARITY_INVERT];
      end
      if (address == `OFS_CTRL2)
      begin
        txEnable        <= writedata[`C2_TE];
        sendBreak       <= writedata[`C2_SBK];
        txEmptyIrqEn    <= writedata[`C2_TEIE];
        txCompleteIrqEn <= writedata[`C2_TX_COMPLETE_IRQ_ENABLE];
      end
      if (address == `OFS_CTRL3)
        txNinth <= writedata[`C3_TXNINTH];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // port pins; pin 0 carries transmit data, pin 1 receive data

  assign txPinOut = txIf.serial ^ txInvert;

  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : gPin
      port_pin_bit uPin (
        .clk      (clk),
        .rst      (rst),
        .pinIn    (pinIn[p]),
        .latchWe  (wrAccept && lane0 && (address == `OFS_PORT_LATCH)),
        .dirWe    (wrAccept && lane0 && (address == `OFS_PORT_DIR)),
        .wrBit    (writedata[p]),
        .owned    (serialEnable),
        .ownOe    (p == 0),
        .ownOut   (txPinOut),
        .pinOut   (pinOut[p]),
        .pinOe    (pinOe[p]),
        .latch    (latch[p]),
        .dir      (dir[p]),
        .readBit  (readBit[p]),
        .pinLevel (pinLevel[p])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // transmitter

  assign tick = baudSourceSelect ? oversampleTickB : oversampleTickA;

  assign txIf.load  = txLoad;
  assign txIf.frame = txFrame;
  assign txIf.nbits = txBits;
  assign txIf.abort = !serialEnable;
  assign txIf.tick  = tick;

  sci_tx_shifter uShifter (
    .clk (clk),
    .rst (rst),
    .tx  (txIf)
  );

  assign dataTransfer = txLoad && txFrame[0] == 1'b0 && txBits != `BITS_ONE
                        && !sendBreak && txFrame != `FRAME_ZEROS;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      txLoad       <= 1'b0;
      txFrame      <= `FRAME_ONES;
      txBits       <= `BITS_CHAR8;
      needPreamble <= 1'b1;
      idleQueued   <= 1'b0;
      breakTail    <= 1'b0;
    end
    else if (!serialEnable)
    begin
      txLoad       <= 1'b0;
      needPreamble <= 1'b1;
      idleQueued   <= 1'b0;
      breakTail    <= 1'b0;
    end
    else
    begin
      txLoad <= 1'b0;
      if (wrAccept && lane0 && address == `OFS_CTRL2 && writedata[`C2_TE] && !txEnable)
      begin
        if (txIf.busy || txLoad)
          idleQueued <= 1'b1;
        else
          needPreamble <= 1'b1;
      end
      if (!txIf.busy && !txLoad)
      begin
        if (txEnable && sendBreak)
        begin
          txLoad    <= 1'b1;
          txFrame   <= `FRAME_ZEROS;
          txBits    <= char9 ? `BITS_CHAR9 : `BITS_CHAR8;
          breakTail <= 1'b1;
        end
        else if (breakTail)
        begin
          txLoad    <= 1'b1;
          txFrame   <= `FRAME_ONES;
          txBits    <= `BITS_ONE;
          breakTail <= 1'b0;
        end
        else if (txEnable && (idleQueued || needPreamble))
        begin
          txLoad       <= 1'b1;
          txFrame      <= `FRAME_ONES;
          txBits       <= char9 ? `BITS_CHAR9 : `BITS_CHAR8;
          idleQueued   <= 1'b0;
          needPreamble <= 1'b0;
        end
        else if (txEnable && !txEmpty)
        begin
          txLoad  <= 1'b1;
          txFrame <= char9 ? {1'b1, txNinth, txData, 1'b0} : {2'b11, txData, 1'b0};
          txBits  <= char9 ? `BITS_CHAR9 : `BITS_CHAR8;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (wrAccept && lane0 && address == `OFS_DATA)
      txData <= writedata[7:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      txEmpty    <= 1'b1;
      emptyArmed <= 1'b0;
    end
    else
    begin
      if (rdAccept && address == `OFS_STATUS1 && txEmpty)
        emptyArmed <= 1'b1;
      if (dataTransfer)
        txEmpty <= 1'b1;
      else if (wrAccept && lane0 && address == `OFS_DATA && emptyArmed)
      begin
        txEmpty    <= 1'b0;
        emptyArmed <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      txComplete <= 1'b1;
    else if (!txIf.busy && !txLoad && txEmpty && !sendBreak && !breakTail && !idleQueued)
      txComplete <= 1'b1;
    else
      txComplete <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      txIrq <= 1'b0;
    else
      txIrq <= (txEmpty && txEmptyIrqEn) || (txComplete && txCompleteIrqEn);
  end

  //////////////////////////////////////////////////////////////////////////
  // receiver: one centre sample per bit; enough to frame and spot breaks

  assign next_rxShift = {pinLevel[1], rxShift[9:1]};
  assign rxDone = rxState == RX_BITS && tick && rxPhase == `TICK_MID
                  && rxCount == (char9 ? 4'ha : 4'h9);

  always_comb
  begin
    next_rxData  = char9 ? next_rxShift[7:0] : next_rxShift[8:1];
    next_rxNinth = next_rxShift[8];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxState <= RX_IDLE;
      rxPhase <= 4'h0;
      rxCount <= 4'h0;
      rxShift <= 10'h000;
      rxPrev  <= 1'b1;
    end
    else
    begin
      rxPrev <= pinLevel[1];
      unique case (rxState)
        RX_IDLE:
          if (serialEnable && rxPrev && !pinLevel[1])
          begin
            rxState <= RX_BITS;
            rxPhase <= 4'h0;
            rxCount <= 4'h0;
          end
        RX_BITS:
          if (!serialEnable)
            rxState <= RX_IDLE;
          else if (tick)
          begin
            rxPhase <= rxPhase + 4'h1;
            if (rxPhase == `TICK_MID)
            begin
              rxCount <= rxCount + 4'h1;
              if (rxCount == 4'h0 && pinLevel[1])
                rxState <= RX_IDLE;
              else if (rxCount != 4'h0)
                rxShift <= next_rxShift;
              if (rxDone)
                rxState <= RX_IDLE;
            end
          end
      endcase
    end
  end

  // flags set on a finished frame win over a clearing read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxData    <= 8'h00;
      rxNinth   <= 1'b0;
      rxFull    <= 1'b0;
      frameErr  <= 1'b0;
      breakFlag <= 1'b0;
    end
    else if (rxDone)
    begin
      rxFull   <= 1'b1;
      frameErr <= !next_rxShift[9];
      if (!next_rxShift[9] && next_rxData == 8'h00 && (!char9 || !next_rxNinth))
      begin
        breakFlag <= 1'b1;
        rxData    <= 8'h00;
        rxNinth   <= 1'b0;
      end
      else
      begin
        rxData  <= next_rxData;
        rxNinth <= next_rxNinth;
      end
    end
    else
    begin
      if (rdAccept && address == `OFS_DATA)
      begin
        rxFull   <= 1'b0;
        frameErr <= 1'b0;
      end
      if (rdAccept && address == `OFS_STATUS2)
        breakFlag <= 1'b0;
    end
  end
endmodule : sci_transmitter_port

/* sci_port_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts for the
  serial transmitter and shared two-pin port. Included by bare name.
*/
`ifndef SCI_PORT_REGS_SVH
`define SCI_PORT_REGS_SVH

// byte offsets on the register bus, one aligned word each
`define OFS_CTRL1        8'h00
`define OFS_CTRL2        8'h04
`define OFS_PORT_LATCH   8'h08
`define OFS_PORT_DIR     8'h0c
`define OFS_STATUS1      8'h10
`define OFS_STATUS2      8'h14
`define OFS_DATA         8'h18
`define OFS_CTRL3        8'h1c

// control register one
`define C1_ENABLE        0
`define C1_CHAR9         1
`define C1_TX_POLARITY_INVERT         2
// control register two
`define C2_TE            0
`define C2_SBK           1
`define C2_TEIE          2
`define C2_TX_COMPLETE_IRQ_ENABLE          3
// control register three
`define C3_RXNINTH       0
`define C3_TXNINTH       1
// status register one
`define S1_TXEMPTY       0
`define S1_TXCOMPLETE    1
`define S1_RXFULL        2
`define S1_FRAMERR       3
// status register two
`define S2_BREAK         0

`define CTRL_RESET       4'h0
`define DIR_RESET        1'b0

// sixteen oversample ticks per bit
`define TICK_LAST        4'hf
`define TICK_MID         4'h7
`define BITS_CHAR8       4'ha
`define BITS_CHAR9       4'hb
`define BITS_ONE         4'h1
`define FRAME_ONES       11'h7ff
`define FRAME_ZEROS      11'h000

`endif

/* sci_port_pkg.sv */
/*
  Types shared by the serial transmitter and port files.
  Assumes nothing of its surroundings.
*/
package sci_port_pkg;
  typedef logic [7:0]  bus_addr_t;
  typedef logic [31:0] bus_data_t;
  typedef enum logic {RX_IDLE, RX_BITS} rx_state_e;
endpackage : sci_port_pkg

/* tx_shift_if.sv */
/*
  Carries a frame from the transmit control logic to the shift engine.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface tx_shift_if;
  logic        load;
  logic [10:0] frame;
  logic [3:0]  nbits;
  logic        abort;
  logic        tick;
  logic        busy;
  logic        lastBit;
  logic        serial;
  modport shifter (input load, frame, nbits, abort, tick, output busy, lastBit, serial);
  modport ctrl    (output load, frame, nbits, abort, tick, input busy, lastBit, serial);
endinterface : tx_shift_if

/* sci_tx_shifter.sv */
/*
  Transmit shift register: shifts a loaded frame out LSB first, one bit per
  sixteen oversample ticks. Assumes ticks are one-cycle pulses on clk.
*/
`timescale 1ns/1ns
`include "sci_port_regs.svh"
module sci_tx_shifter (
  input  wire logic clk,
  input  wire logic rst,
  tx_shift_if.shifter tx
);
  import sci_port_pkg::*;

  logic [10:0] shiftReg;
  logic [3:0]  bitsLeft;
  logic [3:0]  phase;
  logic        busy;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shiftReg <= `FRAME_ONES;
      bitsLeft <= 4'h0;
      phase    <= 4'h0;
      busy     <= 1'b0;
    end
    else if (tx.abort)
    begin
      shiftReg <= `FRAME_ONES;
      bitsLeft <= 4'h0;
      busy     <= 1'b0;
    end
    else if (tx.load && !busy)
    begin
      shiftReg <= tx.frame;
      bitsLeft <= tx.nbits;
      phase    <= 4'h0;
      busy     <= 1'b1;
    end
    else if (busy && tx.tick)
    begin
      phase <= phase + 4'h1;
      if (phase == `TICK_LAST)
      begin
        shiftReg <= {1'b1, shiftReg[10:1]};
        bitsLeft <= bitsLeft - 4'h1;
        if (bitsLeft == `BITS_ONE)
          busy <= 1'b0;
      end
    end
  end

  assign tx.busy    = busy;
  assign tx.lastBit = busy && (bitsLeft == `BITS_ONE);
  assign tx.serial  = shiftReg[0];
endmodule : sci_tx_shifter

/* port_pin_bit.sv */
/*
  One general-purpose port pin: output latch, direction bit, input
  synchroniser, readback select and takeover by the serial module.
  Assumes pinIn is asynchronous to clk.
*/
`timescale 1ns/1ns
`include "sci_port_regs.svh"
module port_pin_bit (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pinIn,
  input  wire logic latchWe,
  input  wire logic dirWe,
  input  wire logic wrBit,
  input  wire logic owned,
  input  wire logic ownOe,
  input  wire logic ownOut,
  output logic      pinOut,
  output logic      pinOe,
  output logic      latch,
  output logic      dir,
  output logic      readBit,
  output logic      pinLevel
);
  import sci_port_pkg::*;

  logic syncFirst;

  always_ff @(posedge clk)
  begin
    if (latchWe)
      latch <= wrBit;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dir <= `DIR_RESET;
    else if (dirWe)
      dir <= wrBit;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      syncFirst <= 1'b1;
      pinLevel  <= 1'b1;
    end
    else
    begin
      syncFirst <= pinIn;
      pinLevel  <= syncFirst;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pinOut  <= 1'b0;
      pinOe   <= 1'b0;
      readBit <= 1'b0;
    end
    else
    begin
      pinOe   <= owned ? ownOe : dir;
      pinOut  <= owned ? ownOut : latch;
      readBit <= dir ? latch : pinLevel;
    end
  end
endmodule : port_pin_bit

/* sci_transmitter_port_chk.sv */
/*
  Checker for the serial transmitter and port top module.
  Assumes register writes carry byteenable[0].
*/
`timescale 1ns/1ns
`include "sci_port_regs.svh"
module sci_transmitter_port_chk (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire sci_port_pkg::bus_addr_t address,
  input wire logic                    read,
  input wire logic                    write,
  input wire sci_port_pkg::bus_data_t writedata,
  input wire logic [3:0]              byteenable,
  input wire sci_port_pkg::bus_data_t readdata,
  input wire logic                    waitrequest,
  input wire logic [1:0]              pinIn,
  input wire logic [1:0]              pinOut,
  input wire logic [1:0]              pinOe,
  input wire logic                    oversampleTickA,
  input wire logic                    oversampleTickB,
  input wire logic                    baudSourceSelect,
  input wire logic                    txIrq
);
  import sci_port_pkg::*;
  logic       wrAcc;
  logic       en;
  logic [1:0] dirS;
  logic [1:0] latchS;
  logic [1:0] irqEn;
  // shadows of accepted writes, so no body access is needed
  assign wrAcc = write && !waitrequest && byteenable[0];
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      en <= 1'b0;
      dirS <= 2'b00;
      irqEn <= 2'b00;
    end
    else if (wrAcc)
    begin
      if (address == `OFS_CTRL1)
        en <= writedata[`C1_ENABLE];
      if (address == `OFS_PORT_DIR)
        dirS <= writedata[1:0];
      if (address == `OFS_CTRL2)
        irqEn <= writedata[`C2_TX_COMPLETE_IRQ_ENABLE:`C2_TEIE];
    end
  // latch keeps its value through reset
  always_ff @(posedge clk)
    if (wrAcc && address == `OFS_PORT_LATCH)
      latchS <= writedata[1:0];
  ////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wait_one_a:
    assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer after one wait state");
  wait_pulse_a:
    assert property (!waitrequest |=> waitrequest)
    else $error("wait state low too long");
  reset_input_a:
    assert property ($fell(rst) |-> pinOe == 2'b00)
    else $error("pins driven after reset");
  port_owned_a:
    assert property (en && $past(en) |=> pinOe == 2'b01)
    else $error("serial pins not owned");
  port_return_a:
    assert property (!en && $past(!en) && $stable(dirS) && $stable(latchS) |->
      pinOe == dirS && (pinOut & dirS) == (latchS & dirS))
    else $error("port pins not under port control");
  read_latch_a:
    assert property (read && !waitrequest && address == `OFS_PORT_LATCH && $stable(dirS)
      |-> (readdata[1:0] & dirS) == (latchS & dirS))
    else $error("output bits not read from latch");
  read_upper_a:
    assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  irq_off_a:
    assert property (irqEn == 2'b00 && $past(irqEn) == 2'b00 |-> !txIrq)
    else $error("interrupt without enable");
endmodule : sci_transmitter_port_chk

bind sci_transmitter_port sci_transmitter_port_chk sci_transmitter_port_chk_inst (
  .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
  .oversampleTickA(oversampleTickA), .oversampleTickB(oversampleTickB),
  .baudSourceSelect(baudSourceSelect), .txIrq(txIrq));

/* remote_uart.sv */
/*
  Remote serial node: decodes frames on the transmit line, sends a break.
  Assumes tick is a one-cycle pulse at sixteen times the baud rate.
*/
`timescale 1ns/1ns
module remote_uart (
  input  wire logic clk,
  input  wire logic tick,
  input  wire logic txLine,
  input  wire logic inv,
  input  wire logic nine,
  output logic      rxLine
);
  int unsigned now     = 0;
  int unsigned startAt = 0;
  int unsigned frames  = 0;
  logic        busy    = 1'b0;
  logic [9:0]  bits;
  logic [7:0]  gotData;
  logic        gotNinth;
  logic        gotStop;
  ////////////////////////
  always @(posedge clk)
    now <= now + 1;
  initial
    rxLine = 1'b1;
  task automatic wait_ticks(input int t);
    int k;
    k = 0;
    while (k < t)
    begin
      @(posedge clk);
      if (tick)
        k++;
    end
  endtask : wait_ticks
  task automatic send_break();
    rxLine <= 1'b0;
    wait_ticks(160);
    rxLine <= 1'b1;
  endtask : send_break
  // a start gone by mid-bit is a glitch
  initial
    forever
    begin
      @(posedge clk);
      if ((txLine ^ inv) === 1'b0)
      begin
        startAt = now;
        wait_ticks(8);
        if ((txLine ^ inv) === 1'b0)
        begin
          busy = 1'b1;
          for (int i = 0; i < (nine ? 10 : 9); i++)
          begin
            wait_ticks(16);
            bits[i] = txLine ^ inv;
          end
          gotData = bits[7:0];
          gotNinth = nine & bits[8];
          gotStop = nine ? bits[9] : bits[8];
          frames++;
          busy = 1'b0;
          for (int j = 0; j < 20000 && (txLine ^ inv) !== 1'b1; j++)
            @(posedge clk);
        end
      end
    end
endmodule : remote_uart

/* sci_transmitter_port_tb.sv */
/*
  Testbench for the serial transmitter and port.
  Assumes the remote node model and the bound checker.
*/
`timescale 1ns/1ns
`include "sci_port_regs.svh"
module sci_transmitter_port_tb;
  import sci_port_pkg::*;
  logic        clk;
  logic        rst = 1'b1;
  bus_addr_t   address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  bus_data_t   writedata = 32'h0;
  logic [3:0]  byteenable = 4'h1;
  bus_data_t   readdata;
  logic        waitrequest;
  logic [1:0]  pinIn;
  logic [1:0]  pinOut;
  logic [1:0]  pinOe;
  logic        tickA = 1'b0;
  logic        tickB = 1'b0;
  logic [3:0]  tickCnt = 4'h0;
  logic        baudSel = 1'b0;
  logic        txIrq;
  logic        extPin0 = 1'b1;
  logic        txLine;
  logic        rxLine;
  logic        invMode = 1'b0;
  logic        nineMode = 1'b0;
  int          errCount = 0;
  int          testsRun = 0;
  int unsigned teAt;
  int          n;
  ////////////////////////
  sci_transmitter_port sci_transmitter_port_inst (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .oversampleTickA(tickA), .oversampleTickB(tickB),
    .baudSourceSelect(baudSel), .txIrq(txIrq));
  remote_uart remote_uart_inst (
    .clk(clk), .tick(baudSel ? tickB : tickA), .txLine(txLine),
    .inv(invMode), .nine(nineMode), .rxLine(rxLine));
  assign txLine = pinOe[0] ? pinOut[0] : extPin0;
  assign pinIn = {pinOe[1] ? pinOut[1] : rxLine, txLine};
  initial
  begin
    clk = 1'b0;
    forever
      #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    tickCnt <= tickCnt + 4'h1;
    tickA <= tickCnt[1:0] == 2'h3;
    tickB <= tickCnt[2:0] == 3'h7;
  end
  ////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task automatic compare(input bus_data_t e, input bus_data_t g);
    testsRun++;
    if (g !== e)
    begin
      errCount++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : compare
  task automatic guard(input logic ok);
    compare(32'h1, {31'h0, ok});
    if (!ok)
      end_of_test();
  endtask : guard
  task automatic xfer(input logic w, input bus_addr_t a, input bus_data_t d, output bus_data_t q);
    int k;
    k = 0;
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 50);
    guard(k < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : xfer
  task automatic wr(input bus_addr_t a, input bus_data_t d);
    bus_data_t q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd_cmp(input bus_addr_t a, input bus_data_t e, input bus_data_t m = 32'hffffffff);
    bus_data_t q;
    xfer(1'b0, a, 32'h0, q);
    compare(e, q & m);
  endtask : rd_cmp
  task automatic load_char(input logic [7:0] d);
    bus_data_t q;
    xfer(1'b0, `OFS_STATUS1, 32'h0, q);
    xfer(1'b1, `OFS_DATA, {24'h0, d}, q);
  endtask : load_char
  task automatic wait_frame();
    int unsigned f;
    int k;
    f = remote_uart_inst.frames;
    for (k = 0; k < 4000 && remote_uart_inst.frames == f; k++)
      @(posedge clk);
    guard(k < 4000);
  endtask : wait_frame
  task automatic check_rx(input logic [9:0] e);
    compare({22'h0, e}, {22'h0, remote_uart_inst.gotStop, remote_uart_inst.gotNinth, remote_uart_inst.gotData});
  endtask : check_rx
  ////////////////////////
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_cmp(`OFS_PORT_DIR, 32'h0);
    rd_cmp(`OFS_STATUS1, 32'h3);
    rd_cmp(8'h40, 32'h0);
    extPin0 <= 1'b0;
    wr(`OFS_PORT_LATCH, 32'h1);
    rd_cmp(`OFS_PORT_LATCH, 32'h2);
    extPin0 <= 1'b1;
    wr(`OFS_PORT_DIR, 32'h3);
    rd_cmp(`OFS_PORT_LATCH, 32'h1);
    compare({30'h0, pinOe}, 32'h3);
    compare({30'h0, pinOut}, 32'h1);
    wr(`OFS_CTRL1, 32'h1);
    compare({30'h0, pinOe}, 32'h1);
    rd_cmp(`OFS_PORT_LATCH, 32'h1);
    wr(`OFS_PORT_DIR, 32'h0);
    rd_cmp(`OFS_PORT_LATCH, 32'h3);
    compare({31'h0, pinOut[0]}, 32'h1);
    wr(`OFS_CTRL2, 32'h5);
    teAt = remote_uart_inst.now;
    load_char(8'ha5);
    wait_frame();
    check_rx(10'h2a5);
    compare({31'h0, remote_uart_inst.startAt - teAt >= 640}, 32'h1);
    rd_cmp(`OFS_STATUS1, 32'h1, 32'h1);
    compare({31'h0, txIrq}, 32'h1);
    wr(`OFS_CTRL1, 32'h3);
    wr(`OFS_CTRL3, 32'h2);
    nineMode <= 1'b1;
    load_char(8'h3c);
    wait_frame();
    check_rx(10'h33c);
    nineMode <= 1'b0;
    baudSel <= 1'b1;
    wr(`OFS_CTRL1, 32'h5);
    invMode <= 1'b1;
    compare({31'h0, pinOut[0]}, 32'h0);
    load_char(8'h81);
    wait_frame();
    check_rx(10'h281);
    wr(`OFS_CTRL1, 32'h1);
    invMode <= 1'b0;
    wr(`OFS_CTRL2, 32'h3);
    wait_frame();
    check_rx(10'h000);
    wr(`OFS_CTRL2, 32'h1);
    for (n = 0; n < 3000 && txLine !== 1'b1; n++)
      @(posedge clk);
    guard(n < 3000);
    remote_uart_inst.send_break();
    rd_cmp(`OFS_STATUS1, 32'hc, 32'hc);
    rd_cmp(`OFS_STATUS2, 32'h1);
    rd_cmp(`OFS_DATA, 32'h0);
    rd_cmp(`OFS_CTRL3, 32'h0, 32'h1);
    load_char(8'h5a);
    for (n = 0; n < 3000 && remote_uart_inst.busy !== 1'b1; n++)
      @(posedge clk);
    guard(n < 3000);
    wr(`OFS_CTRL2, 32'h0);
    wait_frame();
    check_rx(10'h25a);
    compare({31'h0, pinOut[0]}, 32'h1);
    wr(`OFS_CTRL2, 32'h1);
    load_char(8'h66);
    for (n = 0; n < 3000 && remote_uart_inst.busy !== 1'b1; n++)
      @(posedge clk);
    guard(n < 3000);
    teAt = remote_uart_inst.startAt;
    wr(`OFS_CTRL2, 32'h0);
    wr(`OFS_CTRL2, 32'h1);
    load_char(8'h99);
    wait_frame();
    wait_frame();
    check_rx(10'h299);
    compare({31'h0, remote_uart_inst.startAt - teAt >= 2560}, 32'h1);
    wr(`OFS_PORT_DIR, 32'h3);
    wr(`OFS_CTRL1, 32'h0);
    compare({30'h0, pinOe}, 32'h3);
    compare({30'h0, pinOut}, 32'h1);
    end_of_test();
  end
endmodule : sci_transmitter_port_tb
